// File: verilog/upc_regs.sv
// USB PHY control and power signalling registers behind a Wishbone slave
//
// Implementation choice: register access over Wishbone.
`timescale 1ns/1ps

module upc_regs (
	// Clock and reset
	input  wire logic                       clk_i,
	input  wire logic                       rst_i,
	// Wishbone slave
	input  wire logic                       wb_cyc_i,
	input  wire logic                       wb_stb_i,
	input  wire logic                       wb_we_i,
	input  wire logic [upc_pkg::ADR_W-1:0]  wb_adr_i,
	input  wire logic [upc_pkg::SEL_W-1:0]  wb_sel_i,
	input  wire logic [upc_pkg::DAT_W-1:0]  wb_dat_i,
	output logic      [upc_pkg::DAT_W-1:0]  wb_dat_o,
	output logic                            wb_ack_o,
	// PHY and suspend controller
	input  wire logic [upc_pkg::LS_W-1:0]   linestate_i,
	input  wire logic                       resume_se0_i,
	input  wire logic                       resume_k_i,
	output logic      [upc_pkg::LS_W-1:0]   linestate_filt_o,
	output logic                            hw_resume_en_o,
	output logic      [upc_pkg::CONF_W-1:0] phy_config_pins_o,
	output logic                            pulldown_disable_o,
	// Power signalling
	output logic                            power_valid_o,
	output logic      [upc_pkg::PWR_DATA_W-1:0] power_data_o,
	// Interrupt
	output logic                            irq_o
);

	// Bus state
	logic                      ack_ff;
	logic                      nxt_ack;
	logic [upc_pkg::DAT_W-1:0] rdat_ff;
	logic [upc_pkg::DAT_W-1:0] nxt_rdat;
	logic                      req;
	logic                      wr_go;
	logic                      rd_go;
	logic [upc_pkg::DAT_W-1:0] wmask;
	logic [upc_pkg::DAT_W-1:0] wval;
	logic                      hit_power;
	logic                      hit_ctrl;
	logic                      hit_stat;
	logic                      hit_mask;
	logic                      hit_line;

	// Register state
	upc_pkg::upc_power_t        power_ff;
	upc_pkg::upc_power_t        nxt_power;
	upc_pkg::upc_ctrl_t         ctrl_ff;
	upc_pkg::upc_ctrl_t         nxt_ctrl;
	logic [upc_pkg::EV_W-1:0]   stat_ff;
	logic [upc_pkg::EV_W-1:0]   nxt_stat;
	logic [upc_pkg::EV_W-1:0]   mask_ff;
	logic [upc_pkg::EV_W-1:0]   nxt_mask;
	logic                       irq_ff;
	logic                       nxt_irq;
	logic [upc_pkg::LS_W-1:0]   ls_prev_ff;
	logic [upc_pkg::LS_W-1:0]   ls_filt;
	logic [upc_pkg::EV_W-1:0]   events;
	logic [upc_pkg::DAT_W-1:0]  power_word;
	logic [upc_pkg::DAT_W-1:0]  ctrl_word;

	// Linestate filter
	upc_filter u_filter (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.ls_raw_i  (linestate_i),
		.log2_i    (ctrl_ff.filt_log2),
		.ls_filt_o (ls_filt)
	);

	// Address decode on word boundaries
	assign req       = wb_cyc_i & wb_stb_i;
	assign hit_power = (wb_adr_i[7:2] == upc_pkg::POWER_OFS[7:2]);
	assign hit_ctrl  = (wb_adr_i[7:2] == upc_pkg::CTRL_OFS[7:2]);
	assign hit_stat  = (wb_adr_i[7:2] == upc_pkg::STAT_OFS[7:2]);
	assign hit_mask  = (wb_adr_i[7:2] == upc_pkg::MASK_OFS[7:2]);
	assign hit_line  = (wb_adr_i[7:2] == upc_pkg::LINE_OFS[7:2]);

	// Writes and read side effects happen on the edge the master sees ack
	assign wr_go = req & wb_we_i & ack_ff;
	assign rd_go = req & ~wb_we_i & ack_ff;

	assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

	// Read images; unlisted bits stay zero
	always_comb begin
		power_word = '0;
		power_word[upc_pkg::PWR_VALID_BIT] = power_ff.valid;
		power_word[upc_pkg::PWR_DATA_LSB +: upc_pkg::PWR_DATA_W] = power_ff.data;
		ctrl_word = '0;
		ctrl_word[upc_pkg::CTRL_PD_BIT]  = ctrl_ff.pd_dis;
		ctrl_word[upc_pkg::CTRL_SE0_BIT] = ctrl_ff.se0_res;
		ctrl_word[upc_pkg::CTRL_K_BIT]   = ctrl_ff.k_res;
		ctrl_word[upc_pkg::CTRL_FILT_LSB +: upc_pkg::FILT_W] = ctrl_ff.filt_log2;
		ctrl_word[upc_pkg::CTRL_HW_BIT]  = ctrl_ff.hw_res;
		ctrl_word[upc_pkg::CTRL_CONF_LSB +: upc_pkg::CONF_W] = ctrl_ff.conf;
	end

	// Merged write data honours byte lanes
	always_comb begin
		wval = (wb_dat_i & wmask) | ({upc_pkg::DAT_W{1'b0}});
	end

	// Bus answer: one wait state, unmapped reads return zero
	always_comb begin
		nxt_ack  = req & ~ack_ff;
		nxt_rdat = rdat_ff;
		if (req & ~ack_ff) begin
			nxt_rdat = '0;
			if (!wb_we_i) begin
				if (hit_power) begin
					nxt_rdat = power_word;
				end else if (hit_ctrl) begin
					nxt_rdat = ctrl_word;
				end else if (hit_stat) begin
					nxt_rdat[upc_pkg::EV_W-1:0] = stat_ff;
				end else if (hit_mask) begin
					nxt_rdat[upc_pkg::EV_W-1:0] = mask_ff;
				end else if (hit_line) begin
					nxt_rdat[upc_pkg::LS_W-1:0] = ls_filt;
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_ff  <= 1'b0;
			rdat_ff <= '0;
		end else begin
			ack_ff  <= nxt_ack;
			rdat_ff <= nxt_rdat;
		end
	end

	// Power signalling register
	always_comb begin
		nxt_power = power_ff;
		if (wr_go && hit_power) begin
			if (wb_sel_i[1]) begin
				nxt_power.valid = wb_dat_i[upc_pkg::PWR_VALID_BIT];
			end
			if (wb_sel_i[0]) begin
				nxt_power.data = wb_dat_i[upc_pkg::PWR_DATA_LSB +: upc_pkg::PWR_DATA_W];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			power_ff <= upc_pkg::POWER_RST;
		end else begin
			power_ff <= nxt_power;
		end
	end

	// PHY control register; a resume event wins over a clearing write
	always_comb begin
		nxt_ctrl = ctrl_ff;
		if (wr_go && hit_ctrl) begin
			if (wb_sel_i[2]) begin
				nxt_ctrl.pd_dis = wval[upc_pkg::CTRL_PD_BIT];
			end
			if (wb_sel_i[1]) begin
				// Writing one keeps a flag; only hardware can set it
				nxt_ctrl.se0_res   = ctrl_ff.se0_res & wval[upc_pkg::CTRL_SE0_BIT];
				nxt_ctrl.k_res     = ctrl_ff.k_res & wval[upc_pkg::CTRL_K_BIT];
				nxt_ctrl.filt_log2 = wval[upc_pkg::CTRL_FILT_LSB +: upc_pkg::FILT_W];
			end
			if (wb_sel_i[0]) begin
				nxt_ctrl.hw_res = wval[upc_pkg::CTRL_HW_BIT];
				nxt_ctrl.conf   = wval[upc_pkg::CTRL_CONF_LSB +: upc_pkg::CONF_W];
			end
		end
		if (resume_se0_i) begin
			nxt_ctrl.se0_res = 1'b1;
		end
		if (resume_k_i) begin
			nxt_ctrl.k_res = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_ff <= upc_pkg::CTRL_RST;
		end else begin
			ctrl_ff <= nxt_ctrl;
		end
	end

	// Events: resumes and any filtered linestate change
	always_comb begin
		events = '0;
		events[upc_pkg::EV_SE0_BIT]  = resume_se0_i;
		events[upc_pkg::EV_K_BIT]    = resume_k_i;
		events[upc_pkg::EV_LINE_BIT] = (ls_filt != ls_prev_ff);
	end

	// Status clears on read, but only the bits the read returned
	always_comb begin
		nxt_stat = stat_ff;
		nxt_mask = mask_ff;
		if (rd_go && hit_stat) begin
			nxt_stat = stat_ff & ~rdat_ff[upc_pkg::EV_W-1:0];
		end
		nxt_stat = nxt_stat | events;
		if (wr_go && hit_mask && wb_sel_i[0]) begin
			nxt_mask = wb_dat_i[upc_pkg::EV_W-1:0];
		end
		nxt_irq = |(nxt_stat & nxt_mask);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stat_ff    <= upc_pkg::STAT_RST;
			mask_ff    <= upc_pkg::MASK_RST;
			irq_ff     <= 1'b0;
			ls_prev_ff <= upc_pkg::LS_RST;
		end else begin
			stat_ff    <= nxt_stat;
			mask_ff    <= nxt_mask;
			irq_ff     <= nxt_irq;
			ls_prev_ff <= ls_filt;
		end
	end

	// Outputs straight from flops
	assign wb_ack_o           = ack_ff;
	assign wb_dat_o           = rdat_ff;
	assign pulldown_disable_o = ctrl_ff.pd_dis;
	assign hw_resume_en_o     = ctrl_ff.hw_res;
	assign phy_config_pins_o  = ctrl_ff.conf;
	assign linestate_filt_o   = ls_filt;
	assign power_valid_o      = power_ff.valid;
	assign power_data_o       = power_ff.data;
	assign irq_o              = irq_ff;

	a_pulldown_write : assert property (@(posedge clk_i) disable iff (rst_i)
		(wr_go && hit_ctrl && wb_sel_i[2]) |=> (pulldown_disable_o == $past(wb_dat_i[upc_pkg::CTRL_PD_BIT])))
		else $error("Pulldown disable did not follow the written bit");

	a_se0_flag_set : assert property (@(posedge clk_i) disable iff (rst_i)
		resume_se0_i |=> ctrl_ff.se0_res ##1 (ctrl_ff.se0_res || $past(wr_go && hit_ctrl)))
		else $error("Reset-resume flag not set after SE0 resume");

	a_k_flag_set : assert property (@(posedge clk_i) disable iff (rst_i)
		resume_k_i |=> ctrl_ff.k_res)
		else $error("Resume flag not set after K resume");

	a_flags_hold : assert property (@(posedge clk_i) disable iff (rst_i)
		(ctrl_ff.se0_res && !(wr_go && hit_ctrl)) |=> ctrl_ff.se0_res)
		else $error("Reset-resume flag dropped without a write");

	a_k_clear : assert property (@(posedge clk_i) disable iff (rst_i)
		(wr_go && hit_ctrl && wb_sel_i[1] && !wb_dat_i[upc_pkg::CTRL_K_BIT] && !resume_k_i) |=> !ctrl_ff.k_res)
		else $error("Resume flag not cleared by writing zero");

	a_se0_clear : assert property (@(posedge clk_i) disable iff (rst_i)
		(wr_go && hit_ctrl && wb_sel_i[1] && !wb_dat_i[upc_pkg::CTRL_SE0_BIT] && !resume_se0_i) |=>
		!ctrl_ff.se0_res)
		else $error("Reset-resume flag not cleared by writing zero");

	a_k_hold : assert property (@(posedge clk_i) disable iff (rst_i)
		(ctrl_ff.k_res && !(wr_go && hit_ctrl)) |=> ctrl_ff.k_res)
		else $error("Resume flag dropped without a write");

	a_hwres_conf : assert property (@(posedge clk_i) disable iff (rst_i)
		(wr_go && hit_ctrl && wb_sel_i[0]) |=>
		(phy_config_pins_o == $past(wb_dat_i[upc_pkg::CTRL_CONF_LSB +: upc_pkg::CONF_W])) &&
		(hw_resume_en_o == $past(wb_dat_i[upc_pkg::CTRL_HW_BIT])))
		else $error("Config pins or resume mode do not match the write");

	a_reserved_zero : assert property (@(posedge clk_i) disable iff (rst_i)
		(wb_ack_o && !wb_we_i && $past(hit_ctrl)) |->
		(wb_dat_o[31:19] == 13'h0000) && (wb_dat_o[17:14] == 4'h0) && (wb_dat_o[3:0] == 4'h0))
		else $error("Reserved control bits read non-zero");

	a_ack_single : assert property (@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |=> !wb_ack_o)
		else $error("Acknowledge held longer than one cycle");

	// Set wins over a clearing read in the same cycle
	a_stat_set : assert property (@(posedge clk_i) disable iff (rst_i)
		(|events) |=> ((stat_ff & $past(events)) == $past(events)))
		else $error("Status bit not set after its event");

	a_stat_sticky : assert property (@(posedge clk_i) disable iff (rst_i)
		!(rd_go && hit_stat) |=> ((stat_ff & $past(stat_ff)) == $past(stat_ff)))
		else $error("Status bit dropped without a status read");

	a_power_write : assert property (@(posedge clk_i) disable iff (rst_i)
		(wr_go && hit_power && wb_sel_i[0]) |=>
		(power_data_o == $past(wb_dat_i[upc_pkg::PWR_DATA_LSB +: upc_pkg::PWR_DATA_W])))
		else $error("Power data did not follow the written byte");

	a_irq_level : assert property (@(posedge clk_i) disable iff (rst_i)
		irq_o == |(stat_ff & mask_ff))
		else $error("Interrupt does not reflect masked status");

endmodule // upc_regs

// File: pkg/upc_pkg.sv
// Package of constants and types for the USB PHY control register slice
package upc_pkg;

	// Bus geometry
	localparam int unsigned ADR_W   = 8;
	localparam int unsigned DAT_W   = 32;
	localparam int unsigned SEL_W   = 4;

	// Register byte offsets
	localparam logic [7:0] POWER_OFS = 8'h3c;
	localparam logic [7:0] CTRL_OFS  = 8'h40;
	localparam logic [7:0] STAT_OFS  = 8'h44;
	localparam logic [7:0] MASK_OFS  = 8'h48;
	localparam logic [7:0] LINE_OFS  = 8'h4c;

	// Power signalling fields
	localparam int unsigned PWR_VALID_BIT = 8;
	localparam int unsigned PWR_DATA_LSB  = 0;
	localparam int unsigned PWR_DATA_W    = 8;

	// PHY control fields
	localparam int unsigned CTRL_PD_BIT   = 18;
	localparam int unsigned CTRL_SE0_BIT  = 13;
	localparam int unsigned CTRL_K_BIT    = 12;
	localparam int unsigned CTRL_FILT_LSB = 8;
	localparam int unsigned FILT_W        = 4;
	localparam int unsigned CTRL_HW_BIT   = 7;
	localparam int unsigned CTRL_CONF_LSB = 4;
	localparam int unsigned CONF_W        = 3;

	// Event status and mask fields
	localparam int unsigned EV_SE0_BIT  = 0;
	localparam int unsigned EV_K_BIT    = 1;
	localparam int unsigned EV_LINE_BIT = 2;
	localparam int unsigned EV_W        = 3;

	// Line state and filter counter
	localparam int unsigned LS_W   = 2;
	localparam int unsigned FCNT_W = 16;

	// Power signalling register
	typedef struct packed {
		logic                  valid;
		logic [PWR_DATA_W-1:0] data;
	} upc_power_t;

	// PHY control register
	typedef struct packed {
		logic              pd_dis;
		logic              se0_res;
		logic              k_res;
		logic [FILT_W-1:0] filt_log2;
		logic              hw_res;
		logic [CONF_W-1:0] conf;
	} upc_ctrl_t;

	// Reset values
	localparam upc_power_t      POWER_RST = '{valid: 1'b0, data: 8'h00};
	localparam upc_ctrl_t       CTRL_RST  = '{pd_dis: 1'b0, se0_res: 1'b0, k_res: 1'b0,
		filt_log2: 4'h0, hw_res: 1'b0, conf: 3'h0};
	localparam logic [EV_W-1:0] STAT_RST  = 3'h0;
	localparam logic [EV_W-1:0] MASK_RST  = 3'h0;
	localparam logic [LS_W-1:0] LS_RST    = 2'h0;

endpackage : upc_pkg

// File: verilog/upc_filter.sv
// Linestate change filter with a programmable power-of-two hold time
`timescale 1ns/1ps

module upc_filter (
	// Clock and reset
	input  wire logic                       clk_i,
	input  wire logic                       rst_i,
	// Raw line state and filter length
	input  wire logic [upc_pkg::LS_W-1:0]   ls_raw_i,
	input  wire logic [upc_pkg::FILT_W-1:0] log2_i,
	// Filtered line state
	output logic      [upc_pkg::LS_W-1:0]   ls_filt_o
);

	logic [upc_pkg::LS_W-1:0]   cand_ff;
	logic [upc_pkg::LS_W-1:0]   nxt_cand;
	logic [upc_pkg::LS_W-1:0]   filt_ff;
	logic [upc_pkg::LS_W-1:0]   nxt_filt;
	logic [upc_pkg::FCNT_W-1:0] cnt_ff;
	logic [upc_pkg::FCNT_W-1:0] nxt_cnt;
	logic [upc_pkg::FCNT_W-1:0] limit;

	// Widest setting is 2**15, so the count fits 16 bits
	assign limit = 16'h0001 << log2_i;

	always_comb begin
		nxt_cand = cand_ff;
		nxt_filt = filt_ff;
		nxt_cnt  = cnt_ff;
		if (ls_raw_i != cand_ff) begin
			// A glitch restarts the hold time
			nxt_cand = ls_raw_i;
			nxt_cnt  = '0;
		end else if (cand_ff != filt_ff) begin
			if (cnt_ff == limit - 16'h0001) begin
				nxt_filt = cand_ff;
				nxt_cnt  = '0;
			end else begin
				nxt_cnt = cnt_ff + 16'h0001;
			end
		end else begin
			nxt_cnt = '0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cand_ff <= upc_pkg::LS_RST;
			filt_ff <= upc_pkg::LS_RST;
			cnt_ff  <= '0;
		end else begin
			cand_ff <= nxt_cand;
			filt_ff <= nxt_filt;
			cnt_ff  <= nxt_cnt;
		end
	end

	assign ls_filt_o = filt_ff;

	a_filt_hold_time : assert property (@(posedge clk_i) disable iff (rst_i)
		(filt_ff != $past(filt_ff)) |-> ($past(cnt_ff) == $past(limit) - 16'h0001))
		else $error("Filtered linestate changed before its hold time");

	a_filt_follows : assert property (@(posedge clk_i) disable iff (rst_i)
		(filt_ff != $past(filt_ff)) |-> (filt_ff == $past(cand_ff)))
		else $error("Filtered linestate took a value that was not held");

endmodule // upc_filter

// File: verification/upc_phy_model.sv
// Behavioural PHY and suspend controller facing the register slice
`timescale 1ns/1ps

module upc_phy_model (
	// Clock
	input  wire logic                     clk_i,
	// Resume ownership from the slice
	input  wire logic                     hw_resume_en_i,
	// Line state and resume events
	output logic      [upc_pkg::LS_W-1:0] linestate_o,
	output logic                          resume_se0_o,
	output logic                          resume_k_o
);
	initial begin
		linestate_o  = 2'h0;
		resume_se0_o = 1'b0;
		resume_k_o   = 1'b0;
	end

	// Raw line moves just after an edge, like a synchronous PHY output
	task automatic set_line(input logic [1:0] v);
		@(posedge clk_i);
		linestate_o <= v;
	endtask

	// One-cycle auto-resume pulse, only while the controller owns resume
	task automatic wake(input logic se0);
		@(posedge clk_i);
		if (hw_resume_en_i) begin
			resume_se0_o <= se0;
			resume_k_o   <= !se0;
		end
		@(posedge clk_i);
		resume_se0_o <= 1'b0;
		resume_k_o   <= 1'b0;
	endtask
endmodule // upc_phy_model

// File: verification/testbench.sv
// Self-checking bench for the USB PHY control register slice
`timescale 1ns/1ps

module testbench;
	typedef struct {
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] wdat;
		logic [31:0] rexp;
		logic [13:0] pins;
	} upc_row_t;

	logic        clk_i     = 1'b0;
	logic        rst_i     = 1'b1;
	logic        wb_cyc    = 1'b0;
	logic        wb_stb    = 1'b0;
	logic        wb_we     = 1'b0;
	logic [7:0]  wb_adr    = 8'h00;
	logic [3:0]  wb_sel    = 4'h0;
	logic [31:0] wb_wdat   = 32'h0;
	logic [31:0] rd;
	int          bad_count = 0;
	int          compares  = 0;
	int          cnt;
	logic [1:0]  v;
	wire  [31:0] wb_dat_o;
	wire         wb_ack_o;
	wire  [1:0]  ls_raw;
	wire         se0_ev;
	wire         k_ev;
	wire  [1:0]  ls_filt;
	wire         hw_res;
	wire  [2:0]  conf;
	wire         pd_off;
	wire         pwr_v;
	wire  [7:0]  pwr_d;
	wire         irq_o;
	wire  [13:0] pins      = {pd_off, hw_res, conf, pwr_v, pwr_d};

	// Write, then read back; pins are {pd, hw, conf, valid, data}
	upc_row_t rows [9] = '{
		'{8'h3c, 4'hf, 32'hffffffff, 32'h000001ff, 14'h01ff},
		'{8'h3c, 4'hf, 32'h000000a5, 32'h000000a5, 14'h00a5},
		'{8'h40, 4'hf, 32'hffffffff, 32'h00040ff0, 14'h3ea5},
		'{8'h40, 4'hf, 32'h00040050, 32'h00040050, 14'h2aa5},
		'{8'h48, 4'hf, 32'hffffffff, 32'h00000007, 14'h2aa5},
		'{8'h50, 4'hf, 32'hffffffff, 32'h00000000, 14'h2aa5},
		'{8'h4c, 4'hf, 32'hffffffff, 32'h00000000, 14'h2aa5},
		'{8'h40, 4'hf, 32'h00000090, 32'h00000090, 14'h12a5},
		'{8'h40, 4'h4, 32'h00040000, 32'h00040090, 14'h32a5}};

	upc_regs upc_regs_i (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
		.wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .linestate_i(ls_raw), .resume_se0_i(se0_ev), .resume_k_i(k_ev),
		.linestate_filt_o(ls_filt), .hw_resume_en_o(hw_res), .phy_config_pins_o(conf),
		.pulldown_disable_o(pd_off), .power_valid_o(pwr_v), .power_data_o(pwr_d), .irq_o(irq_o));

	upc_phy_model upc_phy_model_i (
		.clk_i(clk_i), .hw_resume_en_i(hw_res), .linestate_o(ls_raw),
		.resume_se0_o(se0_ev), .resume_k_o(k_ev));

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Classic cycle; released only after the edge that samples ack
	task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk_i);
		wb_cyc  <= 1'b1;
		wb_stb  <= 1'b1;
		wb_we   <= w;
		wb_adr  <= a;
		wb_sel  <= s;
		wb_wdat <= d;
		// Only the watchdog ends a wait for ack
		do begin
			@(posedge clk_i);
		end while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wb(1'b1, a, 4'hf, d, rd);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		wb(1'b0, a, 4'hf, 32'h0, rd);
		chk(rd, exp);
	endtask

	task automatic results;
		$display("Comparisons %0d, mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	initial begin
		forever #5 clk_i = ~clk_i;
	end

	// Whole run needs well under 2000 cycles
	initial begin
		#200000;
		bad_count++;
		results();
	end

	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		foreach (rows[i]) begin
			wb(1'b1, rows[i].adr, rows[i].sel, rows[i].wdat, rd);
			rdc(rows[i].adr, rows[i].rexp);
			chk({18'h0, pins}, {18'h0, rows[i].pins});
		end
		// K then SE0 auto-resume with mask open
		for (int s = 0; s < 2; s++) begin
			upc_phy_model_i.wake(s[0]);
			#1;
			chk({31'h0, irq_o}, 32'h1);
			wr(8'h40, 32'h00043090);
			rdc(8'h40, s[0] ? 32'h00042090 : 32'h00041090);
			rdc(8'h44, s[0] ? 32'h1 : 32'h2);
			rdc(8'h44, 32'h0);
			chk({31'h0, irq_o}, 32'h0);
			wr(8'h40, 32'h00040090);
			rdc(8'h40, 32'h00040090);
		end
		// Masked event must not interrupt
		wr(8'h48, 32'h0);
		upc_phy_model_i.wake(1'b0);
		repeat (2) @(posedge clk_i);
		chk({31'h0, irq_o}, 32'h0);
		rdc(8'h44, 32'h2);
		wr(8'h40, 32'h00040090);
		// Software-polled resume and filter length 2^0 and 2^3
		for (int n = 0; n < 4; n += 3) begin
			wr(8'h40, {20'h0, n[3:0], 8'h00});
			upc_phy_model_i.wake(1'b1);
			rdc(8'h40, {20'h0, n[3:0], 8'h00});
			chk({31'h0, pd_off}, 32'h0);
			v = {n[0], ~n[0]};
			cnt = 0;
			upc_phy_model_i.set_line(v);
			do begin
				@(posedge clk_i);
				#1;
				cnt++;
			end while (ls_filt !== v && cnt < 100);
			chk(cnt, (1 << n) + 1);
			rdc(8'h4c, {30'h0, v});
			rdc(8'h44, 32'h4);
		end
		// Second reset in mid-run
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		chk({18'h0, pins}, 32'h0);
		rdc(8'h3c, 32'h0);
		rdc(8'h40, 32'h0);
		rdc(8'h48, 32'h0);
		results();
	end
endmodule // testbench
